// File: src/power_state_sequencer.sv
// Power-state sequencer: start-up, timeslots, shutdown and retries.

// What this block does
// - Enabled alarm counts as start-up event.
// - Adaptor feedback above 4.0V starts device.
// - USB above main supply starts device.
// - Ignore start events below supply threshold.
// - USB suspend picks battery, else USB trickle.
// - Battery connection alone never starts device.
// - Flags for start from off, sleep.
// - Flags for fault restarts and watchdog timeouts.
// - Flags for GPIO power, key, wake presses.
// - Irq when any wake flag set.
// - Mask bits suppress irq, not flags; reset unmasked.
// - Fourteen timeslots, each block one slot.
// - Advance after 1.28ms when slot supplies good.
// - Shutdown events send active/sleep to off.
// - GPIO power-off held 40ms shuts down.
// - Key held 10s, or 5s, shuts down.
// - Key polarity bit, reset active-low.
// - Watchdog shuts down on the eighth fault.
// - Start-up sets chip-on; writing zero powers down.
// - Shutdown asserts resets, returns control and mask registers to reset values, enters off.
// - Only fault-enabled supplies trigger shutdown handling.
// - Start-up faults retry up to eight at 200ms, else off.
// - Fault during sleep goes to off.
module power_state_sequencer #(
    parameter int NUM_SUPPLIES = power_seq_pkg::NUM_SUPPLIES,
    parameter int KEY_LONG_TICKS = power_seq_pkg::KEY_OFF_LONG_TICKS,
    parameter int KEY_SHORT_TICKS = power_seq_pkg::KEY_OFF_SHORT_TICKS,
    parameter int RETRY_TICKS = power_seq_pkg::RETRY_TICKS,
    parameter int SLOT_TICKS = power_seq_pkg::SLOT_TICKS
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Register port
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    output logic [15:0] reg_rdata_o,
    // Start-up sources
    input wire logic power_key_i,
    input wire logic gpio_wake_i,
    input wire logic gpio_power_request_i,
    input wire logic gpio_power_off_request_i,
    input wire logic alarm_i,
    input wire logic alarm_enable_i,
    input wire logic adaptor_above_4v_i,
    input wire logic usb_above_line_i,
    input wire logic usb_suspend_i,
    input wire logic battery_present_i,
    input wire logic line_above_threshold_i,
    // Shutdown sources
    input wire logic thermal_shutdown_i,
    input wire logic watchdog_timeout_i,
    input wire logic sleep_request_i,
    // Supplies
    input wire logic [NUM_SUPPLIES*4-1:0] supply_slot_i,
    input wire logic [NUM_SUPPLIES-1:0] supply_fault_shutdown_en_i,
    input wire logic [NUM_SUPPLIES-1:0] supply_good_i,
    input wire logic [NUM_SUPPLIES-1:0] supply_fault_i,
    output logic [NUM_SUPPLIES-1:0] supply_enable_o,
    // Power path and resets
    output logic run_on_battery_o,
    output logic usb_trickle_100ma_o,
    output logic cpu_reset_n_o,
    output logic memory_reset_out_n_o,
    output logic wake_first_level_irq_o,
    output logic active_o
);

    // ****************************************************************
    // Timing base
    // ****************************************************************
    localparam int TW = power_seq_pkg::TIMER_W;
    localparam int SW = power_seq_pkg::SLOT_W;
    localparam int CW = power_seq_pkg::CNT_W;

    logic tick;
    logic key_active;
    logic key_on_hit, key_off_hit, wake_hit, pwr_hit, off_hit;
    logic [TW-1:0] key_off_limit;
    logic [15:0] sys_ctrl1;
    logic [power_seq_pkg::WAKE_BITS-1:0] wake_status, wake_mask;
    logic [power_seq_pkg::WAKE_BITS-1:0] wake_set;
    power_seq_pkg::pwr_state_t state;
    logic [SW-1:0] slot;
    logic [TW-1:0] timer;
    logic [CW-1:0] retry_count, wdog_count;
    logic restart_cause_fault;
    logic start_from_off, start_from_sleep;
    logic start_event, supply_fault, shutdown_event, slot_good;
    logic seq_done, alarm_q, adaptor_q, usb_q;

    tick_divider #(.DIV(power_seq_pkg::TICK_CYCLES)) u_div (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .tick_o(tick)
    );

    // Polarity bit set means the key is active low.
    assign key_active = sys_ctrl1[power_seq_pkg::BIT_KEY_POL] ?
        !power_key_i : power_key_i;
    assign key_off_limit = sys_ctrl1[power_seq_pkg::BIT_OFF_DEB_SEL] ?
        TW'(KEY_SHORT_TICKS) : TW'(KEY_LONG_TICKS);

    // ****************************************************************
    // Press qualifiers
    // ****************************************************************
    // Start-up presses must exceed 40ms of held level.
    hold_detect #(.TICKS(power_seq_pkg::PRESS_TICKS), .W(TW)) u_key_on (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .tick_i(tick),
        .limit_i('0), .use_limit_i(1'b0),
        .active_i(key_active), .hit_o(key_on_hit)
    );
    hold_detect #(.TICKS(power_seq_pkg::PRESS_TICKS), .W(TW)) u_wake (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .tick_i(tick),
        .limit_i('0), .use_limit_i(1'b0),
        .active_i(gpio_wake_i), .hit_o(wake_hit)
    );
    hold_detect #(.TICKS(power_seq_pkg::PRESS_TICKS), .W(TW)) u_pwr (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .tick_i(tick),
        .limit_i('0), .use_limit_i(1'b0),
        .active_i(gpio_power_request_i), .hit_o(pwr_hit)
    );
    hold_detect #(.TICKS(power_seq_pkg::PRESS_TICKS), .W(TW)) u_off (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .tick_i(tick),
        .limit_i('0), .use_limit_i(1'b0),
        .active_i(gpio_power_off_request_i), .hit_o(off_hit)
    );
    // The off detector only counts while running, so a start press
    // held into ACTIVE begins its long count afresh.
    hold_detect #(.TICKS(1), .W(TW)) u_key_off (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .tick_i(tick),
        .limit_i(key_off_limit), .use_limit_i(1'b1),
        .active_i(key_active && active_o), .hit_o(key_off_hit)
    );

    // Level sources are edge detected so a held level is one event.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            alarm_q <= 1'b0;
            adaptor_q <= 1'b0;
            usb_q <= 1'b0;
        end else begin
            alarm_q <= alarm_i && alarm_enable_i;
            adaptor_q <= adaptor_above_4v_i;
            usb_q <= usb_above_line_i;
        end
    end

    // Battery presence alone is deliberately not a start source.
    assign start_event = line_above_threshold_i &&
        (key_on_hit || wake_hit || pwr_hit ||
         (alarm_i && alarm_enable_i && !alarm_q) ||
         (adaptor_above_4v_i && !adaptor_q) ||
         (usb_above_line_i && !usb_q));

    // ****************************************************************
    // Supply slots and faults
    // ****************************************************************
    // Each supply is enabled from its own slot onward.
    always_comb begin
        slot_good = 1'b1;
        supply_fault = 1'b0;
        for (int i = 0; i < NUM_SUPPLIES; i++) begin
            if (supply_slot_i[i*4 +: 4] == slot && !supply_good_i[i]) begin
                slot_good = 1'b0;
            end
            if (supply_fault_i[i] && supply_fault_shutdown_en_i[i]) begin
                supply_fault = 1'b1;
            end
        end
    end
    assign seq_done = slot == SW'(power_seq_pkg::NUM_SLOTS - 1);

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            supply_enable_o <= '0;
        end else begin
            for (int i = 0; i < NUM_SUPPLIES; i++) begin
                supply_enable_o[i] <= (state == power_seq_pkg::ST_SEQ &&
                    supply_slot_i[i*4 +: 4] <= slot) ||
                    state == power_seq_pkg::ST_ACTIVE ||
                    state == power_seq_pkg::ST_SLEEP;
            end
        end
    end

    // Software clearing chip-on, thermal, off pin, long key, watchdog.
    assign shutdown_event = (reg_wr_i &&
        reg_addr_i == power_seq_pkg::ADDR_SYS_CTRL1 &&
        !reg_wdata_i[power_seq_pkg::BIT_CHIP_ON]) ||
        thermal_shutdown_i || off_hit || key_off_hit ||
        (watchdog_timeout_i &&
         wdog_count >= CW'(power_seq_pkg::WDOG_FAULT_LIMIT));

    // ****************************************************************
    // Main state machine
    // ****************************************************************
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state <= power_seq_pkg::ST_OFF;
            slot <= '0;
            timer <= '0;
            retry_count <= '0;
            restart_cause_fault <= 1'b0;
            start_from_off <= 1'b0;
            start_from_sleep <= 1'b0;
        end else begin
            start_from_off <= 1'b0;
            start_from_sleep <= 1'b0;
            case (state)
                power_seq_pkg::ST_OFF: begin
                    slot <= '0;
                    timer <= '0;
                    if (start_event) begin
                        state <= power_seq_pkg::ST_SEQ;
                        start_from_off <= 1'b1;
                        restart_cause_fault <= 1'b0;
                    end
                end
                power_seq_pkg::ST_SEQ: begin
                    if (supply_fault) begin
                        if (sys_ctrl1[power_seq_pkg::BIT_RETRY_EN] &&
                            retry_count < CW'(power_seq_pkg::MAX_RETRIES)) begin
                            state <= power_seq_pkg::ST_RETRY_WAIT;
                            retry_count <= retry_count + CW'(1);
                            timer <= '0;
                        end else begin
                            state <= power_seq_pkg::ST_OFF;
                            retry_count <= '0;
                        end
                    end else if (tick) begin
                        if (timer + TW'(1) >= TW'(SLOT_TICKS)
                            && slot_good) begin
                            timer <= '0;
                            if (seq_done) begin
                                state <= power_seq_pkg::ST_ACTIVE;
                                retry_count <= '0;
                            end else begin
                                slot <= slot + SW'(1);
                            end
                        end else if (timer + TW'(1) <
                            TW'(SLOT_TICKS)) begin
                            timer <= timer + TW'(1);
                        end
                    end
                end
                power_seq_pkg::ST_RETRY_WAIT: begin
                    slot <= '0;
                    if (tick) begin
                        if (timer + TW'(1) >= TW'(RETRY_TICKS)) begin
                            state <= power_seq_pkg::ST_SEQ;
                            restart_cause_fault <= 1'b1;
                            timer <= '0;
                        end else begin
                            timer <= timer + TW'(1);
                        end
                    end
                end
                power_seq_pkg::ST_ACTIVE: begin
                    if (shutdown_event || supply_fault) begin
                        state <= power_seq_pkg::ST_OFF;
                    end else if (sleep_request_i) begin
                        state <= power_seq_pkg::ST_SLEEP;
                    end
                end
                power_seq_pkg::ST_SLEEP: begin
                    if (shutdown_event || supply_fault) begin
                        state <= power_seq_pkg::ST_OFF;
                    end else if (start_event || !sleep_request_i) begin
                        state <= power_seq_pkg::ST_ACTIVE;
                        start_from_sleep <= 1'b1;
                    end
                end
                default: state <= power_seq_pkg::ST_OFF;
            endcase
        end
    end

    // Watchdog faults are counted across restarts until shutdown.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wdog_count <= '0;
        end else if (state == power_seq_pkg::ST_OFF) begin
            wdog_count <= '0;
        end else if (watchdog_timeout_i &&
            wdog_count < CW'(power_seq_pkg::WDOG_FAULT_LIMIT)) begin
            wdog_count <= wdog_count + CW'(1);
        end
    end

    // ****************************************************************
    // Outputs: power path and resets
    // ****************************************************************
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            run_on_battery_o <= 1'b0;
            usb_trickle_100ma_o <= 1'b0;
            cpu_reset_n_o <= 1'b0;
            memory_reset_out_n_o <= 1'b0;
            active_o <= 1'b0;
        end else begin
            if (start_from_off) begin
                run_on_battery_o <= usb_suspend_i ? battery_present_i :
                    !usb_above_line_i;
                usb_trickle_100ma_o <= usb_above_line_i && !usb_suspend_i;
            end else if (state == power_seq_pkg::ST_OFF) begin
                usb_trickle_100ma_o <= 1'b0;
            end
            cpu_reset_n_o <= state == power_seq_pkg::ST_ACTIVE;
            memory_reset_out_n_o <= state == power_seq_pkg::ST_ACTIVE;
            active_o <= state == power_seq_pkg::ST_ACTIVE;
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    // Control is reset on every entry to OFF, as well as at power-up.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sys_ctrl1 <= power_seq_pkg::SYS_CTRL1_RESET;
            wake_mask <= '0;
        end else if (state == power_seq_pkg::ST_OFF) begin
            sys_ctrl1 <= power_seq_pkg::SYS_CTRL1_RESET;
            wake_mask <= '0;
        end else begin
            if (state == power_seq_pkg::ST_ACTIVE && !cpu_reset_n_o) begin
                sys_ctrl1[power_seq_pkg::BIT_CHIP_ON] <= 1'b1;
            end else if (reg_wr_i &&
                reg_addr_i == power_seq_pkg::ADDR_SYS_CTRL1) begin
                sys_ctrl1 <= reg_wdata_i & power_seq_pkg::SYS_CTRL1_WMASK;
            end
            if (reg_wr_i && reg_addr_i == power_seq_pkg::ADDR_WAKE_MASK) begin
                wake_mask <= reg_wdata_i[power_seq_pkg::WAKE_BITS-1:0];
            end
        end
    end

    // Cause flags are set from qualified events.
    always_comb begin
        wake_set = '0;
        wake_set[power_seq_pkg::FLAG_OFF] = start_from_off;
        wake_set[power_seq_pkg::FLAG_SLEEP] = start_from_sleep;
        wake_set[power_seq_pkg::FLAG_FAULT] = state ==
            power_seq_pkg::ST_ACTIVE && !active_o && restart_cause_fault;
        wake_set[power_seq_pkg::FLAG_WDOG] = watchdog_timeout_i &&
            state != power_seq_pkg::ST_OFF;
        wake_set[power_seq_pkg::FLAG_GPIO_PWR] = pwr_hit &&
            line_above_threshold_i;
        wake_set[power_seq_pkg::FLAG_KEY] = key_on_hit &&
            line_above_threshold_i;
        wake_set[power_seq_pkg::FLAG_GPIO_WAKE] = wake_hit &&
            line_above_threshold_i;
    end

    // A set arriving with the read-clear wins, so no event is lost.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wake_status <= '0;
        end else if (reg_rd_i &&
            reg_addr_i == power_seq_pkg::ADDR_WAKE_STATUS) begin
            wake_status <= wake_set;
        end else begin
            wake_status <= wake_status | wake_set;
        end
    end

    // Read data and irq are registered.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reg_rdata_o <= 16'h0000;
            wake_first_level_irq_o <= 1'b0;
        end else begin
            wake_first_level_irq_o <= |(wake_status & ~wake_mask);
            if (!reg_rd_i) begin
                reg_rdata_o <= reg_rdata_o;
            end else if (reg_addr_i == power_seq_pkg::ADDR_SYS_CTRL1) begin
                reg_rdata_o <= sys_ctrl1;
            end else if (reg_addr_i == power_seq_pkg::ADDR_WAKE_STATUS) begin
                reg_rdata_o <= {9'h000, wake_status};
            end else if (reg_addr_i == power_seq_pkg::ADDR_WAKE_MASK) begin
                reg_rdata_o <= {9'h000, wake_mask};
            end else begin
                reg_rdata_o <= 16'h0000;
            end
        end
    end

endmodule

// File: src/power_seq_pkg.sv
// Shared constants for the power-state sequencer.
package power_seq_pkg;

    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int CLK_HZ = 20_000_000;
    localparam int TICK_US = 10;
    localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
    localparam int PRESS_MS = 40;
    localparam int PRESS_TICKS = PRESS_MS * 1000 / TICK_US + 1;
    localparam int SLOT_US = 1280;
    localparam int SLOT_TICKS = SLOT_US / TICK_US;
    localparam int RETRY_MS = 200;
    localparam int RETRY_TICKS = RETRY_MS * 1000 / TICK_US;
    localparam int KEY_OFF_LONG_S = 10;
    localparam int KEY_OFF_SHORT_S = 5;
    localparam int KEY_OFF_LONG_TICKS = KEY_OFF_LONG_S * 100_000 + 1;
    localparam int KEY_OFF_SHORT_TICKS = KEY_OFF_SHORT_S * 100_000 + 1;
    localparam int TIMER_W = 24;

    // ****************************************************************
    // Sequencer shape
    // ****************************************************************
    localparam int NUM_SLOTS = 14;
    localparam int SLOT_W = 4;
    localparam int NUM_SUPPLIES = 11;
    localparam int MAX_RETRIES = 8;
    localparam int WDOG_FAULT_LIMIT = 7;
    localparam int CNT_W = 4;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] ADDR_SYS_CTRL1 = 8'h03;
    localparam logic [7:0] ADDR_WAKE_STATUS = 8'h1F;
    localparam logic [7:0] ADDR_WAKE_MASK = 8'h27;
    localparam int BIT_CHIP_ON = 15;
    localparam int BIT_RETRY_EN = 13;
    localparam int BIT_OFF_DEB_SEL = 3;
    localparam int BIT_KEY_POL = 1;
    localparam logic [15:0] SYS_CTRL1_RESET = 16'h0002;
    localparam logic [15:0] SYS_CTRL1_WMASK = 16'hA00A;
    localparam int WAKE_BITS = 7;
    localparam int FLAG_OFF = 6;
    localparam int FLAG_SLEEP = 5;
    localparam int FLAG_FAULT = 4;
    localparam int FLAG_WDOG = 3;
    localparam int FLAG_GPIO_PWR = 2;
    localparam int FLAG_KEY = 1;
    localparam int FLAG_GPIO_WAKE = 0;

    // ****************************************************************
    // Power states
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_OFF, ST_SEQ, ST_ACTIVE, ST_SLEEP, ST_RETRY_WAIT
    } pwr_state_t;

endpackage

// File: src/tick_divider.sv
// Divider that issues a one-cycle enable every DIV clocks.
module tick_divider #(
    parameter int DIV = 200
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Enable pulse
    output logic tick_o
);

    logic [15:0] count;

    // Free-running count; the pulse is registered so it is glitch free.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            count <= 16'h0000;
            tick_o <= 1'b0;
        end else if (count == 16'(DIV - 1)) begin
            count <= 16'h0000;
            tick_o <= 1'b1;
        end else begin
            count <= count + 16'h0001;
            tick_o <= 1'b0;
        end
    end

endmodule

// File: src/hold_detect.sv
// Qualifier that pulses once when an input stays active long enough.
module hold_detect #(
    parameter int TICKS = 4001,
    parameter int W = 24
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Timing
    input wire logic tick_i,
    input wire logic [W-1:0] limit_i,
    input wire logic use_limit_i,
    // Level to qualify
    input wire logic active_i,
    // One pulse per press
    output logic hit_o
);

    logic [W-1:0] count;
    logic fired;
    logic [W-1:0] target;

    assign target = use_limit_i ? limit_i : W'(TICKS);

    // Count ticks while active; fire once so a held key is one event.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            count <= '0;
            fired <= 1'b0;
            hit_o <= 1'b0;
        end else if (!active_i) begin
            count <= '0;
            fired <= 1'b0;
            hit_o <= 1'b0;
        end else if (tick_i && !fired && count + W'(1) >= target) begin
            fired <= 1'b1;
            hit_o <= 1'b1;
        end else begin
            if (tick_i && !fired) begin
                count <= count + W'(1);
            end
            hit_o <= 1'b0;
        end
    end

endmodule

// File: bench/power_seq_sva.sv
// Port-level checker for the power-state sequencer.
module power_seq_sva #(parameter int NUM_SUPPLIES = 11) (
    // Watched ports
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic thermal_shutdown_i,
    input wire logic [NUM_SUPPLIES-1:0] supply_enable_o,
    input wire logic cpu_reset_n_o,
    input wire logic memory_reset_out_n_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);
    property p_cpu; thermal_shutdown_i |=> ##1 !cpu_reset_n_o; endproperty
    a_cpu: assert property (p_cpu) else $error("cpu reset blip");
    property p_mem; memory_reset_out_n_o |-> cpu_reset_n_o; endproperty
    a_mem: assert property (p_mem) else $error("memory reset");
    property p_th; thermal_shutdown_i |-> ##[1:3] supply_enable_o == 0;
    endproperty
    a_th: assert property (p_th) else $error("thermal stop");
    property p_hold; !reg_rd_i |=> $stable(reg_rdata_o); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_ctl; reg_rd_i && reg_addr_i == 8'h03 |=>
        (reg_rdata_o & 16'h5FF5) == 0; endproperty
    a_ctl: assert property (p_ctl) else $error("control bits");
    property p_msk; reg_rd_i && reg_addr_i == 8'h27 |=>
        reg_rdata_o[15:7] == 0; endproperty
    a_msk: assert property (p_msk) else $error("mask bits");
    property p_sts; reg_rd_i && reg_addr_i == 8'h1F |=>
        reg_rdata_o[15:7] == 0; endproperty
    a_sts: assert property (p_sts) else $error("status bits");
    property p_map; reg_rd_i && !(reg_addr_i inside {8'h03, 8'h1F, 8'h27})
        |=> reg_rdata_o == 0; endproperty
    a_map: assert property (p_map) else $error("unmapped read");
    c_en: cover property ($rose(supply_enable_o[0]));
    c_th: cover property (thermal_shutdown_i && supply_enable_o != 0);
    c_rd: cover property (reg_rd_i && reg_addr_i == 8'h1F);
endmodule
bind power_state_sequencer power_seq_sva #(.NUM_SUPPLIES(NUM_SUPPLIES)) chk (
    .clk_i, .reset_n_i, .reg_rd_i, .reg_addr_i, .reg_rdata_o,
    .thermal_shutdown_i, .supply_enable_o, .cpu_reset_n_o,
    .memory_reset_out_n_o);

// File: bench/supply_model.sv
// Behavioural regulators behind the sequencer's enable outputs.
module supply_model #(parameter int N = 11) (
    // Sequencer side
    input wire logic clk_i,
    input wire logic [N-1:0] enable_i,
    input wire logic [N-1:0] fail_i,
    output logic [N-1:0] good_o,
    output logic [N-1:0] fault_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [N-1:0] ramp;
    // A short ramp keeps runs brief; a failed block never comes good.
    always_ff @(posedge clk_i) begin
        ramp <= enable_i;
    end
    assign good_o = ramp & enable_i & ~fail_i;
    assign fault_o = ramp & fail_i;
endmodule

// File: bench/testbench.sv
// Self-checking bench for the power-state sequencer.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int N = power_seq_pkg::NUM_SUPPLIES;
    logic clk_i = 0;
    logic reset_n_i = 0;
    logic reg_wr_i = 0;
    logic reg_rd_i = 0;
    logic [7:0] reg_addr_i = 0;
    logic [15:0] reg_wdata_i = 0;
    logic [15:0] reg_rdata_o;
    // Sources: wdog therm alarm_en batt line gpwr wake usb adaptor alarm.
    logic [9:0] ev = 0;
    logic slp = 0;
    logic [N-1:0] fail = 0;
    logic [N-1:0] fen = 1;
    logic [N-1:0] en;
    logic [N-1:0] good;
    logic [N-1:0] flt;
    logic [5:0] o;
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;
    power_state_sequencer #(.KEY_LONG_TICKS(50), .KEY_SHORT_TICKS(25),
        .RETRY_TICKS(20), .SLOT_TICKS(8)) dut (.clk_i, .reset_n_i,
        .reg_wr_i, .reg_rd_i,
        .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .power_key_i(1'b1),
        .gpio_wake_i(ev[3]), .gpio_power_request_i(ev[4]),
        .gpio_power_off_request_i(1'b0), .alarm_i(ev[0]),
        .alarm_enable_i(ev[7]), .adaptor_above_4v_i(ev[1]),
        .usb_above_line_i(ev[2]), .usb_suspend_i(1'b0),
        .battery_present_i(ev[6]), .line_above_threshold_i(ev[5]),
        .thermal_shutdown_i(ev[8]), .watchdog_timeout_i(ev[9]),
        .sleep_request_i(slp), .supply_slot_i({{(N-3){4'hF}}, 12'h010}),
        .supply_fault_shutdown_en_i(fen), .supply_good_i(good),
        .supply_fault_i(flt), .supply_enable_o(en),
        .run_on_battery_o(o[5]), .usb_trickle_100ma_o(o[4]),
        .cpu_reset_n_o(o[3]), .memory_reset_out_n_o(o[2]),
        .wake_first_level_irq_o(o[1]), .active_o(o[0]));
    supply_model #(.N(N)) far (.clk_i, .enable_i(en), .fail_i(fail),
        .good_o(good), .fault_o(flt));
    // Free-running clock at 20 MHz.
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    // A hung run counts as a mismatch and closes the report.
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            mismatches++;
            give_verdict();
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_i);
        reg_wr_i <= 1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i <= 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk_i);
        reg_rd_i <= 1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_rd_i <= 0;
        #1;
        check(reg_rdata_o, e);
    endtask
    task automatic give_verdict();
        if (mismatches == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Main sequence: registers, refused starts, start, slots, shutdowns.
    initial begin
        cyc(12);
        reset_n_i <= 1;
        rd(8'h03, 16'h0002);
        rd(8'h27, 16'h0000);
        rd(8'h55, 16'h0000);
        wr(8'h03, 16'hFFFF);
        rd(8'h03, 16'h0002);
        ev <= 10'h079;
        cyc(400);
        ev <= 10'h0C0;
        cyc(4);
        ev <= 10'h0C1;
        cyc(400);
        check(16'(en), 16'h0000);
        rd(8'h1F, 16'h0000);
        ev <= 10'h0E0;
        cyc(4);
        ev <= 10'h0E1;
        cyc(300);
        check(16'(en), 16'h0005);
        check(16'(o[1]), 16'h0001);
        wr(8'h27, 16'h007F);
        cyc(3);
        check(16'(o[1]), 16'h0000);
        ev <= 10'h2E1;
        cyc(1);
        ev <= 10'h0E1;
        rd(8'h1F, 16'h0048);
        rd(8'h1F, 16'h0000);
        wr(8'h27, 16'h0000);
        cyc(1000);
        check(16'(en), 16'h0005);
        cyc(500);
        check(16'(en), 16'h0007);
        fail <= 4;
        cyc(20);
        check(16'(en), 16'h0007);
        fail <= 5;
        cyc(20);
        check(16'({en, o[3]}), 16'h0000);
        fail <= 0;
        ev <= 10'h060;
        cyc(4);
        ev <= 10'h062;
        cyc(300);
        check(16'(en), 16'h0005);
        cyc(22200);
        check(16'({en, o[3]}), 16'h0FFF);
        rd(8'h03, 16'h8002);
        slp <= 1;
        cyc(5);
        slp <= 0;
        cyc(5);
        rd(8'h1F, 16'h0060);
        ev <= 10'h162;
        cyc(10);
        check(16'(en), 16'h0000);
        ev <= 10'h060;
        cyc(4);
        ev <= 10'h064;
        cyc(300);
        check(16'({en, o[5:4]}), 16'h0015);
        give_verdict();
    end
endmodule
